// file: rtl/nts_pkg.sv
// Constants, types and field positions for the sentence/pulse time receiver.
// Assumes one 25 MHz clock and a synchronous active-high reset.
//
// What this block does
// - Characters are eight data bits, one stop bit, no flow control.
// - Pulse rising edge is the second announced by the next RMC sentence.
// - Talker prefixes GA, GB, GI, GL, GN, GP, GQ are all accepted.
// - Fix quality reads 0 invalid, 1 standard fix, 2 differential fix.
// - Latitude and longitude are signed 32-bit degrees times ten million.
// - Time is whole seconds since 1970-01-01 00:00 UTC.
// - With reception, the time base aligns itself without any command.
// - Alignment needs both a valid RMC sentence and a present pulse.
// - Height, geoid separation, speed in km/h, course and declination reported.
// - Satellites used and horizontal, position, vertical dilution reported.
// - Navigation rate must not exceed the fastest other channel's rate.
package nts_pkg;

  localparam int CLK_HZ_DEF = 25_000_000;
  localparam int NBAUD = 6;
  localparam int BAUD_BPS [NBAUD] = '{4800, 9600, 19200, 38400, 57600, 115200};
  localparam int PPS_LOSS_S = 2;

  // Register offsets, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00, REG_STAT = 8'h04, REG_RATE = 8'h08,
    REG_EPOCH = 8'h0C, REG_LAT = 8'h10, REG_LON = 8'h14, REG_HGT = 8'h18,
    REG_GEOID = 8'h1C, REG_SPEED = 8'h20, REG_COURSE = 8'h24, REG_MAGV = 8'h28,
    REG_QSAT = 8'h2C, REG_HDOP = 8'h30, REG_PDOP = 8'h34, REG_VDOP = 8'h38;
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam int CTRL_EN_BIT = 3;
  localparam int ST_SYNCED = 0, ST_PPS_OK = 1, ST_CKERR = 2, ST_FRERR = 3,
    ST_OVR = 4, ST_RBAD = 5;

  // Sentence field positions
  localparam logic [4:0] F_TIME = 5'h01, F_STAT = 5'h02, F_LAT = 5'h03, F_NS = 5'h04,
    F_LON = 5'h05, F_EW = 5'h06, F_SPD = 5'h07, F_CRS = 5'h08, F_DATE = 5'h09,
    F_MAGV = 5'h0A, F_MAGEW = 5'h0B;
  localparam logic [4:0] F_QUAL = 5'h06, F_SATS = 5'h07, F_HDOP = 5'h08,
    F_HGT = 5'h09, F_GEOID = 5'h0B;
  localparam logic [4:0] F_PDOP = 5'h0F, F_HDOP2 = 5'h10, F_VDOP = 5'h11;

  // Fixed-point scaling of results
  localparam logic [2:0] FRAC_STD = 3'h2, FRAC_LL = 3'h5;
  localparam longint LL_DEG_DIV = 64'd10_000_000;
  localparam longint KMH_NUM = 64'd1852, KMH_DEN = 64'd1000;
  localparam longint DAYS_1970_2000 = 64'd10957, SEC_DAY = 64'd86400;

  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24, CH_STAR = 8'h2A, CH_COMMA = 8'h2C,
    CH_DOT = 8'h2E, CH_MINUS = 8'h2D, CH_ZERO = 8'h30, CH_NINE = 8'h39,
    CH_A = 8'h41, CH_S = 8'h53, CH_W = 8'h57, CH_G = 8'h47;
  localparam logic [23:0] TY_RMC = 24'h524D43, TY_GGA = 24'h474741, TY_GSA = 24'h475341;

  typedef enum logic [3:0] {
    MSG_NONE = 4'b0001, MSG_RMC = 4'b0010, MSG_GGA = 4'b0100, MSG_GSA = 4'b1000
  } nts_msg_t;

  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001, PS_BODY = 4'b0010, PS_CK1 = 4'b0100, PS_CK2 = 4'b1000
  } nts_ps_t;

  typedef struct packed {
    logic [31:0] epoch;
    logic [31:0] lat;
    logic [31:0] lon;
    logic [31:0] height;
    logic [31:0] geoid;
    logic [31:0] speed;
    logic [31:0] course;
    logic [31:0] magvar;
    logic [1:0] quality;
    logic [7:0] sats;
    logic [15:0] hdop;
    logic [15:0] pdop;
    logic [15:0] vdop;
  } nts_nav_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [2:0] fd;
    logic dot;
    logic neg;
    logic [7:0] lch;
    logic [2:0] nd;
    logic [23:0] dg;
  } nts_fld_t;

endpackage

// file: rtl/nts_buf.sv
// Small ready/valid buffer between the serial receiver and the parser.
// Assumes both sides on the same clock; depth fixed by parameter.
`timescale 1ns/1ps
`default_nettype none
module nts_buf
#(
  parameter int W = 8,
  parameter int DEPTH = 2
)(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } nts_bst_t;

  nts_bst_t s_ff;
  nts_bst_t nxt_s;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign o_ready = (s_ff.cnt != FULL);
  assign o_valid = (s_ff.cnt != '0);
  assign o_data = s_ff.mem[s_ff.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointer and count update
  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wp] = i_data;
      nxt_s.wp = (s_ff.wp == LAST) ? '0 : s_ff.wp + 1'b1;
    end
    if (pop)
      nxt_s.rp = (s_ff.rp == LAST) ? '0 : s_ff.rp + 1'b1;
    if (push && !pop)
      nxt_s.cnt = s_ff.cnt + 1'b1;
    else if (pop && !push)
      nxt_s.cnt = s_ff.cnt - 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

endmodule // nts_buf
`default_nettype wire

// file: rtl/nts_rx_top.sv
// Sentence/pulse time receiver: serial receive, parse, checksum, align.
// Assumes serial and pulse inputs already synchronous to i_sys_clk.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module nts_rx_top
  import nts_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
)(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_rx,
  input wire logic i_pps,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  output var nts_nav_t o_nav,
  output logic o_synced,
  output logic o_sync_pulse,
  output logic o_rate_bad
);
  localparam logic [31:0] SUB_MAX = 32'(CLK_HZ - 1);
  localparam logic [31:0] SUB_HALF = 32'(CLK_HZ / 2);
  localparam logic [1:0] AGE_LOSS = 2'(PPS_LOSS_S);

  typedef struct packed {
    logic [15:0] u_cnt;
    logic [3:0] u_bit;
    logic [7:0] u_sh;
    logic ub_vld;
    logic [7:0] ub_data;
    nts_ps_t ps;
    nts_msg_t msg;
    logic [4:0] fi;
    logic [7:0] xs;
    logic [3:0] ck_hi;
    logic [39:0] hdr;
    nts_fld_t f;
    logic [23:0] tdig;
    logic [23:0] ddig;
    logic fixa;
    nts_nav_t sh;
    nts_nav_t res;
    logic cm;
    logic [31:0] sub;
    logic [1:0] age;
    logic [1:0] since;
    logic pend;
    logic pps_q;
    logic synced;
    logic spulse;
    logic [31:0] ctrl;
    logic [31:0] rate;
    logic cke;
    logic fre;
    logic ovr;
    logic rbad;
    logic [31:0] rdat;
  } nts_st_t;

  nts_st_t s_ff;
  nts_st_t nxt_s;
  logic buf_rdy;
  logic b_vld;
  logic [7:0] b_data;
  logic b_take;
  logic tick;
  logic edge_p;

  // Cycles per bit; rates above the list clamp to the fastest
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int idx;
    idx = (int'(sel) < NBAUD) ? int'(sel) : NBAUD - 1;
    return 16'(CLK_HZ / BAUD_BPS[idx]);
  endfunction

  function automatic logic [31:0] pow10(input logic [2:0] k);
    case (k)
      3'h0: return 32'h1;
      3'h1: return 32'hA;
      3'h2: return 32'h64;
      3'h3: return 32'h3E8;
      3'h4: return 32'h2710;
      default: return 32'h186A0;
    endcase
  endfunction

  // Non-hex characters give the out-of-range value 5'h10; as first checksum character it is flagged at once
  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= CH_ZERO && c <= CH_NINE)
      return 5'(c - CH_ZERO);
    else if (c >= CH_A && c <= 8'h46)
      return 5'(c - 8'h37);
    else
      return 5'h10;
  endfunction

  function automatic logic talker_ok(input logic [15:0] t);
    logic [7:0] b;
    b = t[7:0];
    return (t[15:8] == CH_G) && (b == 8'h41 || b == 8'h42 || b == 8'h49 ||
      b == 8'h4C || b == 8'h4E || b == 8'h50 || b == 8'h51);
  endfunction

  function automatic nts_msg_t msg_of(input logic [39:0] h);
    if (!talker_ok(h[39:24]))
      return MSG_NONE;
    case (h[23:0])
      TY_RMC: return MSG_RMC;
      TY_GGA: return MSG_GGA;
      TY_GSA: return MSG_GSA;
      default: return MSG_NONE;
    endcase
  endfunction

  // dddmm.mmmmm times 1e5 into degrees times 1e7
  function automatic logic [31:0] ll_conv(input logic [31:0] v);
    longint deg;
    longint mn;
    deg = longint'(v) / LL_DEG_DIV;
    mn = longint'(v) - deg * LL_DEG_DIV;
    return 32'(deg * LL_DEG_DIV + (mn * 64'd5) / 64'd3);
  endfunction

  function automatic longint two_dig(input logic [7:0] d);
    return longint'(d[7:4]) * 64'd10 + longint'(d[3:0]);
  endfunction

  function automatic longint month_days(input longint m);
    case (m)
      64'd2: return 64'd31;
      64'd3: return 64'd59;
      64'd4: return 64'd90;
      64'd5: return 64'd120;
      64'd6: return 64'd151;
      64'd7: return 64'd181;
      64'd8: return 64'd212;
      64'd9: return 64'd243;
      64'd10: return 64'd273;
      64'd11: return 64'd304;
      64'd12: return 64'd334;
      default: return 64'd0;
    endcase
  endfunction

  // hhmmss and ddmmyy digits to seconds since 1970; years 2000..2099 only
  function automatic logic [31:0] epoch_of(input logic [23:0] t, input logic [23:0] d);
    longint yy;
    longint mo;
    longint days;
    yy = two_dig(d[7:0]);
    mo = two_dig(d[15:8]);
    days = DAYS_1970_2000 + yy * 64'd365 + (yy + 64'd3) / 64'd4 + month_days(mo)
      + two_dig(d[23:16]) - 64'd1;
    if (mo > 64'd2 && yy % 64'd4 == 64'd0)
      days = days + 64'd1;
    return 32'(days * SEC_DAY + two_dig(t[23:16]) * 64'd3600
      + two_dig(t[15:8]) * 64'd60 + two_dig(t[7:0]));
  endfunction

  // Two-entry buffer; parser stalls for the commit cycle
  nts_buf #(
    .W(8),
    .DEPTH(2)
  ) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_valid(s_ff.ub_vld),
    .o_ready(buf_rdy),
    .i_data(s_ff.ub_data),
    .o_valid(b_vld),
    .i_ready(!s_ff.cm),
    .o_data(b_data)
  );

  assign b_take = b_vld && !s_ff.cm;
  assign tick = (s_ff.sub == SUB_MAX);
  assign edge_p = i_pps && !s_ff.pps_q;

  // Whole next state
  always_comb
  begin
    logic [7:0] c;
    logic [7:0] d;
    logic [2:0] nf;
    logic [31:0] val;
    logic [31:0] sv;
    logic [31:0] stat;
    logic [15:0] div;
    logic [4:0] hv;
    c = b_data;
    d = b_data - CH_ZERO;
    nf = (s_ff.msg == MSG_RMC && (s_ff.fi == F_LAT || s_ff.fi == F_LON)) ? FRAC_LL : FRAC_STD;
    val = 32'(s_ff.f.acc * pow10(3'(nf - s_ff.f.fd)));
    sv = s_ff.f.neg ? -val : val;
    div = baud_div(s_ff.ctrl[2:0]);
    hv = hexval(b_data); // A call result cannot be part-selected directly
    stat = '0;
    stat[ST_SYNCED] = s_ff.synced;
    stat[ST_PPS_OK] = (s_ff.age < AGE_LOSS);
    stat[ST_CKERR] = s_ff.cke;
    stat[ST_FRERR] = s_ff.fre;
    stat[ST_OVR] = s_ff.ovr;
    stat[ST_RBAD] = s_ff.rbad;
    nxt_s = s_ff;
    nxt_s.ub_vld = 1'b0;
    nxt_s.cm = 1'b0;
    nxt_s.spulse = 1'b0;
    nxt_s.rdat = '0;

    // Register port; sticky clears come first so a same-cycle set wins
    if (i_wr)
    begin
      case (i_addr)
        REG_CTRL: nxt_s.ctrl = i_wr_data;
        REG_RATE: nxt_s.rate = i_wr_data;
        REG_STAT:
        begin
          if (i_wr_data[ST_CKERR]) nxt_s.cke = 1'b0;
          if (i_wr_data[ST_FRERR]) nxt_s.fre = 1'b0;
          if (i_wr_data[ST_OVR]) nxt_s.ovr = 1'b0;
        end
        default: nxt_s.ctrl = s_ff.ctrl;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        REG_CTRL: nxt_s.rdat = s_ff.ctrl;
        REG_STAT: nxt_s.rdat = stat;
        REG_RATE: nxt_s.rdat = s_ff.rate;
        REG_EPOCH: nxt_s.rdat = s_ff.res.epoch;
        REG_LAT: nxt_s.rdat = s_ff.res.lat;
        REG_LON: nxt_s.rdat = s_ff.res.lon;
        REG_HGT: nxt_s.rdat = s_ff.res.height;
        REG_GEOID: nxt_s.rdat = s_ff.res.geoid;
        REG_SPEED: nxt_s.rdat = s_ff.res.speed;
        REG_COURSE: nxt_s.rdat = s_ff.res.course;
        REG_MAGV: nxt_s.rdat = s_ff.res.magvar;
        REG_QSAT: nxt_s.rdat = {22'h0, s_ff.res.quality, s_ff.res.sats};
        REG_HDOP: nxt_s.rdat = {16'h0, s_ff.res.hdop};
        REG_PDOP: nxt_s.rdat = {16'h0, s_ff.res.pdop};
        REG_VDOP: nxt_s.rdat = {16'h0, s_ff.res.vdop};
        default: nxt_s.rdat = '0;
      endcase
    end
    // Navigation rate may never exceed the fastest other channel's; a tie passes
    nxt_s.rbad = (s_ff.rate[31:16] < s_ff.rate[15:0]);

    // 8N1 receiver, mid-bit sampling, rate from the control register
    if (!s_ff.ctrl[CTRL_EN_BIT])
      nxt_s.u_bit = 4'h0;
    else if (s_ff.u_bit == 4'h0)
    begin
      if (!i_rx)
      begin
        nxt_s.u_bit = 4'h1;
        nxt_s.u_cnt = div >> 1;
      end
    end
    else if (s_ff.u_cnt != 16'h0)
      nxt_s.u_cnt = s_ff.u_cnt - 16'h1;
    else
    begin
      nxt_s.u_cnt = div - 16'h1;
      if (s_ff.u_bit == 4'h1)
        nxt_s.u_bit = i_rx ? 4'h0 : 4'h2; // Glitch start bits drop out
      else if (s_ff.u_bit < 4'hA)
      begin
        nxt_s.u_sh = {i_rx, s_ff.u_sh[7:1]};
        nxt_s.u_bit = s_ff.u_bit + 4'h1;
      end
      else
      begin
        nxt_s.u_bit = 4'h0;
        nxt_s.ub_vld = i_rx;
        nxt_s.ub_data = s_ff.u_sh;
        if (!i_rx)
          nxt_s.fre = 1'b1;
      end
    end
    // The line cannot be held off, so a full buffer costs a character
    if (s_ff.ub_vld && !buf_rdy)
      nxt_s.ovr = 1'b1;

    // Sentence parser
    if (b_take)
    begin
      if (c == CH_DOLLAR)
      begin
        nxt_s.ps = PS_BODY;
        nxt_s.msg = MSG_NONE;
        nxt_s.fi = 5'h0;
        nxt_s.xs = 8'h0;
        nxt_s.f = '0;
        nxt_s.sh = s_ff.res;
      end
      else
      begin
        case (s_ff.ps)
          PS_BODY:
          begin
            if (c == CH_STAR || c == CH_COMMA)
            begin
              // Field complete: scale and file it
              nxt_s.f = '0;
              if (c == CH_STAR)
                nxt_s.ps = PS_CK1;
              else
              begin
                nxt_s.fi = s_ff.fi + 5'h1;
                nxt_s.xs = s_ff.xs ^ c;
              end
              if (s_ff.fi == 5'h0)
                nxt_s.msg = msg_of(s_ff.hdr);
              case (s_ff.msg)
                MSG_RMC:
                begin
                  case (s_ff.fi)
                    F_TIME: nxt_s.tdig = s_ff.f.dg;
                    F_STAT: nxt_s.fixa = (s_ff.f.lch == CH_A);
                    F_LAT: nxt_s.sh.lat = ll_conv(val);
                    F_NS: if (s_ff.f.lch == CH_S) nxt_s.sh.lat = -s_ff.sh.lat;
                    F_LON: nxt_s.sh.lon = ll_conv(val);
                    F_EW: if (s_ff.f.lch == CH_W) nxt_s.sh.lon = -s_ff.sh.lon;
                    F_SPD: nxt_s.sh.speed = 32'((longint'(val) * KMH_NUM) / KMH_DEN);
                    F_CRS: nxt_s.sh.course = val;
                    F_DATE: nxt_s.ddig = s_ff.f.dg;
                    F_MAGV: nxt_s.sh.magvar = val;
                    F_MAGEW: if (s_ff.f.lch == CH_W) nxt_s.sh.magvar = -s_ff.sh.magvar;
                    default: nxt_s.fixa = s_ff.fixa;
                  endcase
                end
                MSG_GGA:
                begin
                  case (s_ff.fi)
                    F_QUAL: nxt_s.sh.quality = (s_ff.f.acc > 32'h2) ? 2'h0 : s_ff.f.acc[1:0];
                    F_SATS: nxt_s.sh.sats = s_ff.f.acc[7:0];
                    F_HDOP: nxt_s.sh.hdop = val[15:0];
                    F_HGT: nxt_s.sh.height = sv;
                    F_GEOID: nxt_s.sh.geoid = sv;
                    default: nxt_s.fixa = s_ff.fixa;
                  endcase
                end
                MSG_GSA:
                begin
                  case (s_ff.fi)
                    F_PDOP: nxt_s.sh.pdop = val[15:0];
                    F_HDOP2: nxt_s.sh.hdop = val[15:0];
                    F_VDOP: nxt_s.sh.vdop = val[15:0];
                    default: nxt_s.fixa = s_ff.fixa;
                  endcase
                end
                default: nxt_s.fixa = s_ff.fixa;
              endcase
            end
            else
            begin
              nxt_s.xs = s_ff.xs ^ c;
              if (s_ff.fi == 5'h0)
                nxt_s.hdr = {s_ff.hdr[31:0], c};
              if (c >= CH_ZERO && c <= CH_NINE)
              begin
                if (!s_ff.f.dot)
                begin
                  nxt_s.f.acc = 32'(s_ff.f.acc * 32'hA + 32'(d[3:0]));
                  if (s_ff.f.nd < 3'h6)
                  begin
                    nxt_s.f.dg = {s_ff.f.dg[19:0], d[3:0]};
                    nxt_s.f.nd = s_ff.f.nd + 3'h1;
                  end
                end
                else if (s_ff.f.fd < nf)
                begin
                  nxt_s.f.acc = 32'(s_ff.f.acc * 32'hA + 32'(d[3:0]));
                  nxt_s.f.fd = s_ff.f.fd + 3'h1;
                end
              end
              else if (c == CH_DOT)
                nxt_s.f.dot = 1'b1;
              else if (c == CH_MINUS)
                nxt_s.f.neg = 1'b1;
              else
                nxt_s.f.lch = c;
            end
          end
          PS_CK1:
          begin
            nxt_s.ck_hi = hv[3:0];
            nxt_s.ps = (hv == 5'h10) ? PS_IDLE : PS_CK2;
            if (hv == 5'h10)
              nxt_s.cke = 1'b1;
          end
          PS_CK2:
          begin
            nxt_s.ps = PS_IDLE;
            if ({1'b0, s_ff.ck_hi, 4'h0} + {4'h0, hexval(c)} == {1'b0, s_ff.xs})
              nxt_s.cm = (s_ff.msg != MSG_NONE);
            else
              nxt_s.cke = 1'b1;
          end
          default: nxt_s.ps = PS_IDLE;
        endcase
      end
    end

    // Commit a checked sentence; the running epoch is never taken from the copy
    if (s_ff.cm)
    begin
      nxt_s.res = s_ff.sh;
      nxt_s.res.epoch = s_ff.res.epoch;
      if (s_ff.msg == MSG_RMC && s_ff.fixa && s_ff.pend && s_ff.age < AGE_LOSS)
      begin
        nxt_s.res.epoch = epoch_of(s_ff.tdig, s_ff.ddig) + 32'(s_ff.since);
        nxt_s.synced = 1'b1;
        nxt_s.spulse = 1'b1;
        nxt_s.pend = 1'b0;
      end
    end

    // Local time base, restarted by each pulse edge
    nxt_s.pps_q = i_pps;
    nxt_s.sub = tick ? 32'h0 : s_ff.sub + 32'h1;
    if (tick)
    begin
      if (s_ff.age != 2'h3) nxt_s.age = s_ff.age + 2'h1;
      if (s_ff.since != 2'h3) nxt_s.since = s_ff.since + 2'h1;
      if (nxt_s.synced) nxt_s.res.epoch = nxt_s.res.epoch + 32'h1;
    end
    if (edge_p)
    begin
      nxt_s.sub = 32'h0;
      nxt_s.age = 2'h0;
      nxt_s.since = 2'h0;
      nxt_s.pend = 1'b1;
      // An early edge would otherwise swallow the coming tick
      if (nxt_s.synced && !tick && s_ff.sub >= SUB_HALF)
        nxt_s.res.epoch = nxt_s.res.epoch + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      s_ff <= '0;
      s_ff.ps <= PS_IDLE;
      s_ff.msg <= MSG_NONE;
      s_ff.ctrl <= CTRL_RST;
      s_ff.rate <= RATE_RST;
      s_ff.age <= 2'h3;
    end
    else
      s_ff <= nxt_s;
  end

  assign o_rd_data = s_ff.rdat;
  assign o_nav = s_ff.res;
  assign o_synced = s_ff.synced;
  assign o_sync_pulse = s_ff.spulse;
  assign o_rate_bad = s_ff.rbad;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  property p_stop_bad;
    (s_ff.u_bit == 4'hA && s_ff.u_cnt == 16'h0 && s_ff.ctrl[CTRL_EN_BIT] && !i_rx)
      |=> !s_ff.ub_vld && s_ff.fre;
  endproperty
  a_stop_bad: assert property (p_stop_bad) else $error("stop bit error not flagged");

  property p_align;
    s_ff.spulse |-> $past(s_ff.cm) && $past(s_ff.pend) && s_ff.synced;
  endproperty
  a_align: assert property (p_align) else $error("alignment without pending edge");

  property p_talker;
    s_ff.cm |-> talker_ok(s_ff.hdr[39:24]);
  endproperty
  a_talker: assert property (p_talker) else $error("sentence committed with bad talker");

  property p_quality;
    s_ff.res.quality != 2'h3;
  endproperty
  a_quality: assert property (p_quality) else $error("fix quality out of range");

  property p_tick;
    (tick && s_ff.synced && !s_ff.cm && !edge_p) |=> s_ff.res.epoch == $past(s_ff.res.epoch) + 32'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("epoch did not advance on tick");

  property p_auto;
    (s_ff.cm && s_ff.msg == MSG_RMC && s_ff.fixa && s_ff.pend && s_ff.age < AGE_LOSS)
      |=> s_ff.spulse ##1 !s_ff.spulse;
  endproperty
  a_auto: assert property (p_auto) else $error("no alignment on valid sentence");

  property p_pps_needed;
    s_ff.spulse |-> $past(s_ff.age) < AGE_LOSS && $past(s_ff.msg) == MSG_RMC;
  endproperty
  a_pps_needed: assert property (p_pps_needed) else $error("aligned without pulse");

  property p_rate;
    (s_ff.rate[31:16] < s_ff.rate[15:0]) [*2] |-> s_ff.rbad;
  endproperty
  a_rate: assert property (p_rate) else $error("rate fault not reported");

  property p_cksum;
    (b_take && s_ff.ps == PS_CK2 && {1'b0, s_ff.ck_hi, 4'h0} + {4'h0, hexval(b_data)}
      != {1'b0, s_ff.xs}) |=> !s_ff.cm ##1 $stable(s_ff.res.lat) && $stable(s_ff.res.sats);
  endproperty
  a_cksum: assert property (p_cksum) else $error("bad checksum sentence committed");

endmodule // nts_rx_top
`default_nettype wire

// file: verif/nts_gnss_model.sv
// Far-side navigation receiver: 8N1 sentences and a second pulse.
// Assumes the caller steps it right after a rising edge of i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module nts_gnss_model
#(
  parameter int BIT_CYC = 4
)(
  input wire logic i_sys_clk,
  output logic o_rx,
  output logic o_pps
);
  // Bit time in clocks; the bench may retune it between sentences
  int bit_cyc = BIT_CYC;
  // Line idles high, pulse rests low
  initial
    begin
      o_rx = 1'b1;
      o_pps = 1'b0;
    end
  // Start bit, eight bits LSB first, one stop bit
  task automatic put(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
      begin
        o_rx <= f[i];
        repeat (bit_cyc) @(posedge i_sys_clk);
      end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Whole sentence; bad flips the checksum so the device must drop it
  task automatic send(input string s, input logic bad);
    logic [7:0] ck;
    ck = 8'h00;
    put(8'h24);
    foreach (s[i])
      begin
        ck = ck ^ s[i];
        put(s[i]);
      end
    ck = ck ^ {7'h00, bad};
    put(8'h2A);
    put(hx(ck[7:4]));
    put(hx(ck[3:0]));
  endtask
  // Rising edge marks the second of the next RMC sentence
  task automatic pulse();
    o_pps <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    o_pps <= 1'b0;
  endtask
  // Line low through the stop bit: a framing fault, no character
  task automatic brk();
    o_rx <= 1'b0;
    repeat (10 * bit_cyc) @(posedge i_sys_clk);
    o_rx <= 1'b1;
  endtask
endmodule // nts_gnss_model
`default_nettype wire

// file: verif/tb_top.sv
// Bench for the sentence/pulse time receiver, register port and serial side.
// Assumes CLK_HZ 460800 so baud select 5 gives four cycles a bit.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nts_pkg::*;
;
  logic clk, rst, rx, pps, wr, rd, synced, spulse, rbad;
  logic [7:0] addr;
  logic [31:0] wdat, rdat;
  nts_nav_t nav;
  int errors, samples_checked, cyc, syncs;
  string tk [7] = '{"GA", "GB", "GI", "GL", "GN", "GP", "GQ"};
  string rmc = "RMC,123519.00,A,4807.0380,N,01130.0000,W,022.4,084.4,010124,003.1,W";
  string gga = "GPGGA,123519.00,4807.0380,N,01130.0000,W,%0d,08,0.9,545.4,M,46.9,M,,";
  logic [7:0] ra [9] = '{REG_LAT, REG_LON, REG_SPEED, REG_COURSE, REG_MAGV, REG_HGT,
    REG_GEOID, REG_PDOP, REG_VDOP};
  logic [31:0] rv [9] = '{32'h1CAE_1E08, 32'hF925_3D40, 32'h0000_1034, 32'h0000_20F8,
    32'hFFFF_FECA, 32'h0000_D50C, 32'h0000_1252, 32'h0000_00FA, 32'h0000_00D2};
  nts_rx_top #(.CLK_HZ(460800)) dut (.i_sys_clk(clk), .i_srst(rst), .i_rx(rx), .i_pps(pps),
    .i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .o_nav(nav),
    .o_synced(synced), .o_sync_pulse(spulse), .o_rate_bad(rbad));
  nts_gnss_model #(.BIT_CYC(4)) gm (.i_sys_clk(clk), .o_rx(rx), .o_pps(pps));
  initial
    begin
      clk = 1'b0;
      forever #20 clk = ~clk;
    end
  // Counts alignments; ceiling well above the ~40k cycles of traffic
  always @(posedge clk)
    begin
      cyc <= cyc + 1;
      syncs <= syncs + (spulse === 1'b1);
      if (cyc == 80000)
        begin
          errors++;
          complete_run();
        end
    end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      begin
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdat, e);
    @(posedge clk);
  endtask
  task automatic sent(input string s, input logic bad);
    gm.send(s, bad);
    repeat (12) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
    begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdat = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd32(REG_CTRL, CTRL_RST);
      rd32(REG_RATE, RATE_RST);
      rd32(8'h3C, 32'h0);
      wr32(REG_CTRL, 32'h0000_000D);
      $display("test registers done");
      sent({"GP", rmc}, 1'b0);
      check(synced, 32'h0);
      foreach (tk[i])
        begin
          gm.pulse();
          sent({tk[i], rmc}, 1'b0);
          check(syncs, i + 1);
          check(nav.epoch, 32'h6592_B187);
        end
      rd32(REG_EPOCH, 32'h6592_B187);
      $display("test alignment done");
      for (int q = 0; q < 3; q++)
        begin
          sent($sformatf(gga, q), 1'b0);
          check(nav.quality, q);
        end
      sent("GPZDA,123519.00,01,01,2024,,", 1'b0);
      sent("GPGSA,A,3,04,05,,,,,,,,,,,2.5,1.3,2.1", 1'b0);
      foreach (ra[i])
        rd32(ra[i], rv[i]);
      rd32(REG_QSAT, 32'h0000_0208);
      rd32(REG_HDOP, 32'h0000_0082);
      $display("test results done");
      sent($sformatf(gga, 1), 1'b1);
      rd32(REG_QSAT, 32'h0000_0208);
      gm.brk();
      repeat (12) @(posedge clk);
      rd32(REG_STAT, 32'h0000_000F);
      wr32(REG_STAT, 32'h0000_000C);
      rd32(REG_STAT, 32'h0000_0003);
      wr32(REG_RATE, 32'h0004_0008);
      repeat (3) @(posedge clk);
      check(rbad, 32'h1);
      wr32(REG_RATE, 32'h0008_0004);
      repeat (3) @(posedge clk);
      check(rbad, 32'h0);
      $display("test faults done");
      wr32(REG_CTRL, 32'h0000_000C);
      gm.bit_cyc = 8;
      sent($sformatf(gga, 1), 1'b0);
      check(nav.quality, 32'h1);
      $display("test rate done");
      complete_run();
    end
endmodule // tb_top
`default_nettype wire
